// ===== rtl/dhi_params.svh
/*
 Constants for the display host interface: strap codes, host register map,
 command codes and link timing. Assumes inclusion by the package and by
 every design file that needs them.
*/
`ifndef DHI_PARAMS_SVH
`define DHI_PARAMS_SVH
// strap codes in order {strap_0, strap_1, strap_2}
`define DHI_STRAP_I2C 3'h2
`define DHI_STRAP_SPI3 3'h4
`define DHI_STRAP_SPI4 3'h0
`define DHI_STRAP_PAR_E 3'h1
`define DHI_STRAP_PAR_RW 3'h3
// host register map
`define DHI_REG_CTRL 8'h00
`define DHI_REG_TX 8'h04
`define DHI_REG_STAT 8'h08
`define DHI_CTRL_RESET_BIT 3
`define DHI_CTRL_SA0_BIT 4
`define DHI_CTRL_RST_VAL 5'h00
`define DHI_TX_DC_BIT 8
`define DHI_TX_RD_BIT 9
// device command handling
`define DHI_CONTRAST_RST 8'h7F
`define DHI_CMD_CONTRAST 8'h81
`define DHI_CMD_DISP_OFF 8'hAE
`define DHI_CMD_DISP_ON 8'hAF
`define DHI_I2C_ADDR_HI 6'h1E
`define DHI_I2C_CTL_DATA 8'h40
`define DHI_I2C_CTL_CMD 8'h00
// timing
`define DHI_CLK_NS 50
`define DHI_HOST_HALF_NS 400
`define DHI_I2C_CYCLE_NS 2500
`endif

// ===== rtl/dhi_pkg.sv
/*
 Types shared by both ends of the display host interface.
 Assumes dhi_params.svh is on the include path.
*/
`include "dhi_params.svh"
package dhi_pkg;
   typedef enum logic [2:0] {DHI_I2C, DHI_SPI3, DHI_SPI4, DHI_PAR_E,
      DHI_PAR_RW, DHI_BAD} dhi_mode_e;
   typedef enum logic [2:0] {HS_IDLE, HS_PSET, HS_PSTB, HS_PEND, HS_SER,
      HS_I2C} dhi_hst_e;
   typedef enum logic [1:0] {I2_ADDR, I2_CTRL, I2_DATA} dhi_i2ph_e;

   // straps given as {strap_0, strap_1, strap_2}
   function automatic dhi_mode_e dhi_mode_of(input logic [2:0] s);
      case (s)
         `DHI_STRAP_I2C: return DHI_I2C;
         `DHI_STRAP_SPI3: return DHI_SPI3;
         `DHI_STRAP_SPI4: return DHI_SPI4;
         `DHI_STRAP_PAR_E: return DHI_PAR_E;
         `DHI_STRAP_PAR_RW: return DHI_PAR_RW;
         default: return DHI_BAD;
      endcase
   endfunction
endpackage

// ===== rtl/dhi_if.sv
/*
 Pin bundle between host and display device.
 Resolves the data lines as pulled-up wired-AND and joins lines two and one
 when the straps select I2C, as the board would.
*/
`timescale 1ns/100ps
`default_nettype none
interface dhi_if;
   import dhi_pkg::*;
   logic protocol_strap_0;
   logic protocol_strap_1;
   logic protocol_strap_2;
   logic cs_n;
   logic data_cmd_sel;
   logic rw_wr_n;
   logic en_rd_n;
   logic panel_reset_n;
   logic [7:0] host_d_o;
   logic [7:0] host_d_oe;
   logic [7:0] dev_d_o;
   logic [7:0] dev_d_oe;
   logic [7:0] lvl;
   logic [7:0] host_data_bus;
   logic is_i2c;

   assign lvl = ~(host_d_oe & ~host_d_o) & ~(dev_d_oe & ~dev_d_o);
   assign is_i2c = dhi_mode_of({protocol_strap_0, protocol_strap_1,
      protocol_strap_2}) == DHI_I2C;
   // tie: lines two and one form one open-drain wire
   assign host_data_bus = is_i2c ?
      {lvl[7:3], {2{lvl[2] & lvl[1]}}, lvl[0]} : lvl;

   modport host (output protocol_strap_0, protocol_strap_1,
      protocol_strap_2, cs_n, data_cmd_sel, rw_wr_n, en_rd_n, panel_reset_n,
      host_d_o, host_d_oe, input host_data_bus);
   modport dev (input protocol_strap_0, protocol_strap_1, protocol_strap_2,
      cs_n, data_cmd_sel, rw_wr_n, en_rd_n, panel_reset_n, host_data_bus,
      output dev_d_o, dev_d_oe);
endinterface
`default_nettype wire

// ===== rtl/dhi_sync.sv
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no word coherence is promised.
*/
`timescale 1ns/100ps
`default_nettype none
module dhi_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // levels
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         meta_ff <= RST_VAL;
         Q <= RST_VAL;
      end else if (CE) begin
         meta_ff <= D;
         Q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dhi_dev.sv
/*
 Device end of the display host interface: strap decode, chip select,
 parallel strobes, SPI and I2C byte receivers, command/data steering,
 contrast and display on/off. Runs on the link clock; every pin is
 synchronised first. Assumes the link clock is well above the pin rates.
*/
// Operation
// - straps pick I2C, SPI3, SPI4 or parallel
// - traffic accepted only while chip select low
// - reset pin low initialises the chip
// - parallel byte steered by data/command line
// - four-wire SPI byte steered by data/command line
// - I2C uses data/command pin as address bit
// - E-strobe mode: direction high reads, low writes
// - E-strobe cycle starts on enable high
// - write strobe low with select starts write
// - read strobe low with select starts read
// - serial modes tie strobe pins to ground
// - eight-bit two-way parallel data bus
// - SPI: line one data, line zero clock
// - I2C: lines two/one joined, zero clock
// - unused data lines tied low except two
// - reset discards partial serial byte
// - reset sets contrast 7Fh, display off
`include "dhi_params.svh"
`timescale 1ns/100ps
`default_nettype none
module dhi_dev (
   // link domain
   input wire logic LINK_CLK,
   input wire logic RST,
   input wire logic CE,
   // pins
   dhi_if.dev LNK,
   // received bytes
   output logic RX_VALID,
   output logic [7:0] RX_BYTE,
   output logic RX_IS_DATA,
   // parallel read-back
   input wire logic [7:0] RD_BYTE,
   // state
   output var dhi_pkg::dhi_mode_e MODE,
   output logic [7:0] CMD_BYTE,
   output logic [7:0] CONTRAST,
   output logic DISPLAY_ON,
   output logic IN_RESET
);
   import dhi_pkg::*;

   logic [15:0] syn;
   logic [3:0] prv_ff;
   logic [7:0] sh_ff;
   logic [3:0] bc_ff;
   logic dcb_ff;
   logic act_ff;
   logic ack_ff;
   logic co_ff;
   logic i2dc_ff;
   dhi_i2ph_e i2ph_ff;
   logic drv_ff;
   logic [7:0] rdq_ff;
   logic argp_ff;

   dhi_sync #(.W(16), .RST_VAL(16'h0000)) u_sync (
      .CLK(LINK_CLK),
      .RST(RST),
      .CE(CE),
      .D({LNK.protocol_strap_0, LNK.protocol_strap_1, LNK.protocol_strap_2,
         LNK.cs_n, LNK.data_cmd_sel, LNK.rw_wr_n, LNK.en_rd_n,
         LNK.panel_reset_n, LNK.host_data_bus}),
      .Q(syn)
   );

   wire logic [2:0] s_strap = syn[15:13];
   wire logic s_cs_n = syn[12];
   wire logic s_dc = syn[11];
   wire logic s_rw = syn[10];
   wire logic s_e = syn[9];
   wire logic s_rstn = syn[8];
   wire logic [7:0] s_d = syn[7:0];

   wire dhi_mode_e mode_w = dhi_mode_of(s_strap);
   wire logic is_i2c = mode_w == DHI_I2C;
   wire logic is_spi3 = mode_w == DHI_SPI3;
   wire logic is_spi4 = mode_w == DHI_SPI4;
   wire logic is_spi = is_spi3 | is_spi4;
   wire logic is_pe = mode_w == DHI_PAR_E;
   wire logic is_prw = mode_w == DHI_PAR_RW;
   wire logic is_par = is_pe | is_prw;
   wire logic init = ~s_rstn;
   wire logic sel = ~s_cs_n;

   // edges on the synchronised copies only
   wire logic clk_rise = s_d[0] & ~prv_ff[3];
   wire logic clk_fall = ~s_d[0] & prv_ff[3];
   wire logic sda_fall = ~s_d[1] & prv_ff[2];
   wire logic sda_rise = s_d[1] & ~prv_ff[2];
   wire logic e_rise = s_e & ~prv_ff[1];
   wire logic wr_fall = ~s_rw & prv_ff[0];

   // SPI: msb first, sampled on clock rise
   wire logic spi_last = is_spi4 ? bc_ff == 4'h7 : bc_ff == 4'h8;
   wire logic spi_dcbit = is_spi3 & bc_ff == 4'h0;
   wire logic spi_ev = is_spi & sel & clk_rise & spi_last;

   // I2C: start/stop while clock high, ack on line two
   wire logic i2_start = is_i2c & sel & s_d[0] & prv_ff[3] & sda_fall;
   wire logic i2_stop = is_i2c & s_d[0] & prv_ff[3] & sda_rise;
   wire logic i2_shift = is_i2c & act_ff & clk_rise & bc_ff < 4'h8;
   wire logic i2_done = is_i2c & act_ff & clk_fall & bc_ff == 4'h8;
   wire logic i2_ackend = is_i2c & act_ff & clk_fall & bc_ff == 4'h9;
   wire logic addr_ok = sh_ff == {`DHI_I2C_ADDR_HI, s_dc, 1'b0};
   wire logic i2_ev = i2_done & i2ph_ff == I2_DATA;

   // parallel strobes
   wire logic par_wr = sel & ((is_pe & e_rise & ~s_rw)
      | (is_prw & wr_fall));
   wire logic par_rd = sel & ((is_pe & s_e & s_rw)
      | (is_prw & ~s_e));

   wire logic byte_ev = ~init & (spi_ev | i2_ev | par_wr);
   wire logic [7:0] byte_val = is_par ? s_d :
      is_i2c ? sh_ff : {sh_ff[6:0], s_d[1]};
   wire logic byte_dc = (is_par | is_spi4) ? s_dc :
      is_spi3 ? dcb_ff : i2dc_ff;

   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         prv_ff <= 4'h0;
         MODE <= DHI_BAD;
         IN_RESET <= 1'b1;
      end else if (CE) begin
         prv_ff <= {s_d[0], s_d[1], s_e, s_rw};
         MODE <= mode_w;
         IN_RESET <= init;
      end
   end

   // serial receivers; chip select high or reset drops a partial byte
   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         sh_ff <= 8'h00;
         bc_ff <= 4'h0;
         dcb_ff <= 1'b0;
         act_ff <= 1'b0;
         ack_ff <= 1'b0;
         co_ff <= 1'b0;
         i2dc_ff <= 1'b0;
         i2ph_ff <= I2_ADDR;
      end else if (CE) begin
         if (init | ~sel) begin
            sh_ff <= 8'h00;
            bc_ff <= 4'h0;
            act_ff <= 1'b0;
            ack_ff <= 1'b0;
         end else if (is_spi & clk_rise) begin
            if (spi_dcbit) begin
               dcb_ff <= s_d[1];
            end else begin
               sh_ff <= {sh_ff[6:0], s_d[1]};
            end
            bc_ff <= spi_last ? 4'h0 : bc_ff + 4'h1;
         end else if (i2_start) begin
            bc_ff <= 4'h0;
            act_ff <= 1'b1;
            ack_ff <= 1'b0;
            i2ph_ff <= I2_ADDR;
         end else if (i2_stop) begin
            bc_ff <= 4'h0;
            act_ff <= 1'b0;
            ack_ff <= 1'b0;
         end else if (i2_shift) begin
            sh_ff <= {sh_ff[6:0], s_d[1]};
            bc_ff <= bc_ff + 4'h1;
         end else if (i2_done) begin
            bc_ff <= 4'h9;
            unique case (i2ph_ff)
               I2_ADDR: begin
                  ack_ff <= addr_ok;
                  act_ff <= addr_ok;
                  i2ph_ff <= I2_CTRL;
               end
               I2_CTRL: begin
                  ack_ff <= 1'b1;
                  co_ff <= sh_ff[7];
                  i2dc_ff <= sh_ff[6];
                  i2ph_ff <= I2_DATA;
               end
               I2_DATA: begin
                  ack_ff <= 1'b1;
                  i2ph_ff <= co_ff ? I2_CTRL : I2_DATA;
               end
               default: begin
                  act_ff <= 1'b0;
               end
            endcase
         end else if (i2_ackend) begin
            ack_ff <= 1'b0;
            bc_ff <= 4'h0;
         end
      end
   end

   // read data latched at strobe start so it holds while driven
   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         drv_ff <= 1'b0;
         rdq_ff <= 8'h00;
      end else if (CE) begin
         drv_ff <= par_rd & ~init;
         if (par_rd & ~drv_ff) begin
            rdq_ff <= RD_BYTE;
         end
      end
   end

   // line two is the open-drain ack; others drive only during reads
   assign LNK.dev_d_o = drv_ff ? rdq_ff : 8'h00;
   assign LNK.dev_d_oe = drv_ff ? 8'hFF : {5'h00, ack_ff, 2'b00};

   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         RX_VALID <= 1'b0;
         RX_BYTE <= 8'h00;
         RX_IS_DATA <= 1'b0;
         CMD_BYTE <= 8'h00;
         CONTRAST <= `DHI_CONTRAST_RST;
         DISPLAY_ON <= 1'b0;
         argp_ff <= 1'b0;
      end else if (CE) begin
         RX_VALID <= byte_ev;
         if (init) begin
            CONTRAST <= `DHI_CONTRAST_RST;
            DISPLAY_ON <= 1'b0;
            CMD_BYTE <= 8'h00;
            argp_ff <= 1'b0;
         end else if (byte_ev) begin
            RX_BYTE <= byte_val;
            RX_IS_DATA <= byte_dc;
            if (~byte_dc) begin
               CMD_BYTE <= byte_val;
               argp_ff <= ~argp_ff & byte_val == `DHI_CMD_CONTRAST;
               if (argp_ff) begin
                  CONTRAST <= byte_val;
               end else if (byte_val == `DHI_CMD_DISP_OFF) begin
                  DISPLAY_ON <= 1'b0;
               end else if (byte_val == `DHI_CMD_DISP_ON) begin
                  DISPLAY_ON <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dhi_host.sv
/*
 Host end of the display host interface: APB slave with control, transmit
 and status registers, and a sequencer that writes one byte over the strapped
 protocol or reads one in a parallel mode. Assumes the device samples pins with its own clock.
*/
`include "dhi_params.svh"
`timescale 1ns/100ps
`default_nettype none
module dhi_host #(
   parameter int HALF = (`DHI_HOST_HALF_NS + `DHI_CLK_NS - 1) / `DHI_CLK_NS,
   parameter int I2C_HALF =
      (`DHI_I2C_CYCLE_NS / 2 + `DHI_CLK_NS - 1) / `DHI_CLK_NS
) (
   // clock
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // pins
   dhi_if.host LNK
);
   import dhi_pkg::*;

   logic [4:0] ctrl_ff;
   dhi_hst_e st_ff;
   logic [7:0] cnt_ff;
   logic ph_ff;
   logic [4:0] idx_ff;
   logic [3:0] bits_ff;
   logic [8:0] sh_ff;
   logic [26:0] fr_ff;
   logic [7:0] byte_ff;
   logic dc_ff;
   logic rd_ff;
   logic [7:0] rdd_ff;
   logic [7:0] d_syn;
   logic [7:0] do_ff;
   logic [7:0] doe_ff;
   logic [2:0] strap_ff;

   dhi_sync #(.W(8), .RST_VAL(8'hFF)) u_sync (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .D(LNK.host_data_bus),
      .Q(d_syn)
   );

   wire dhi_mode_e mode_w = dhi_mode_of(ctrl_ff[2:0]);
   wire logic is_i2c = mode_w == DHI_I2C;
   wire logic is_spi3 = mode_w == DHI_SPI3;
   wire logic is_spi = is_spi3 | mode_w == DHI_SPI4;
   wire logic is_pe = mode_w == DHI_PAR_E;
   wire logic is_prw = mode_w == DHI_PAR_RW;
   wire logic is_par = is_pe | is_prw;
   wire logic sa0 = ctrl_ff[`DHI_CTRL_SA0_BIT];

   wire logic hit_ctrl = PADDR == `DHI_REG_CTRL;
   wire logic hit_tx = PADDR == `DHI_REG_TX;
   wire logic hit_stat = PADDR == `DHI_REG_STAT;
   wire logic acc = PSEL & PENABLE;
   wire logic busy = st_ff != HS_IDLE;
   // transmit while busy is dropped; status shows busy
   wire logic wr_tx = acc & PWRITE & hit_tx & ~busy;
   assign PREADY = 1'b1;
   assign PSLVERR = acc & ~(hit_ctrl | hit_tx | hit_stat);

   wire logic [7:0] half_len = is_i2c ? 8'(I2C_HALF - 1) : 8'(HALF - 1);
   wire logic [7:0] mid = 8'(I2C_HALF / 2);
   wire logic tick = cnt_ff == 8'h00;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl_ff <= `DHI_CTRL_RST_VAL;
         PRDATA <= 32'h0000_0000;
      end else if (CE) begin
         if (acc & PWRITE & hit_ctrl) begin
            ctrl_ff <= PWDATA[4:0];
         end
         if (PSEL & ~PENABLE) begin
            PRDATA <= hit_ctrl ? {27'h0, ctrl_ff} :
               hit_stat ? {16'h0, rdd_ff, 7'h0, busy} : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_ff <= HS_IDLE;
         cnt_ff <= 8'h00;
         ph_ff <= 1'b0;
         idx_ff <= 5'h00;
         bits_ff <= 4'h0;
         sh_ff <= 9'h000;
         fr_ff <= 27'h0;
         byte_ff <= 8'h00;
         dc_ff <= 1'b0;
         rd_ff <= 1'b0;
         rdd_ff <= 8'h00;
      end else if (CE) begin
         cnt_ff <= (~busy | tick) ? half_len : cnt_ff - 8'h01;
         unique case (st_ff)
            HS_IDLE: if (wr_tx) begin
               byte_ff <= PWDATA[7:0];
               dc_ff <= PWDATA[`DHI_TX_DC_BIT];
               rd_ff <= PWDATA[`DHI_TX_RD_BIT] & is_par;
               ph_ff <= 1'b0;
               idx_ff <= 5'h00;
               sh_ff <= is_spi3 ? {PWDATA[`DHI_TX_DC_BIT], PWDATA[7:0]} :
                  {PWDATA[7:0], 1'b0};
               bits_ff <= is_spi3 ? 4'h9 : 4'h8;
               fr_ff <= {`DHI_I2C_ADDR_HI, sa0, 1'b0, 1'b1,
                  PWDATA[`DHI_TX_DC_BIT] ? `DHI_I2C_CTL_DATA :
                  `DHI_I2C_CTL_CMD, 1'b1, PWDATA[7:0], 1'b1};
               st_ff <= is_par ? HS_PSET : is_i2c ? HS_I2C :
                  is_spi ? HS_SER : HS_IDLE;
            end
            HS_PSET: if (tick) st_ff <= HS_PSTB;
            HS_PSTB: if (tick) begin
               if (rd_ff) begin
                  rdd_ff <= d_syn;
               end
               st_ff <= HS_PEND;
            end
            HS_PEND: if (tick) st_ff <= HS_IDLE;
            HS_SER: if (tick) begin
               ph_ff <= ~ph_ff;
               if (ph_ff) begin
                  sh_ff <= {sh_ff[7:0], 1'b0};
                  bits_ff <= bits_ff - 4'h1;
                  if (bits_ff == 4'h1) st_ff <= HS_IDLE;
               end
            end
            HS_I2C: if (tick) begin
               ph_ff <= ~ph_ff;
               if (ph_ff) begin
                  idx_ff <= idx_ff + 5'h01;
                  if (idx_ff != 5'h00) fr_ff <= {fr_ff[25:0], 1'b0};
                  if (idx_ff == 5'h1C) st_ff <= HS_IDLE;
               end
            end
         endcase
      end
   end

   // pin values before their output flops
   wire logic strb = st_ff == HS_PSTB;
   wire logic i2_scl = ~busy | idx_ff == 5'h00 | ph_ff;
   wire logic i2_sda_lo = busy & ((idx_ff == 5'h00 & ph_ff) |
      idx_ff == 5'h1C | (idx_ff != 5'h00 & ~fr_ff[26]));
   wire logic [7:0] nxt_do = is_par ? byte_ff :
      is_spi ? {6'h00, sh_ff[8], ph_ff & st_ff == HS_SER} :
      {7'h00, i2_scl};
   // serial modes: unused lines low, line two left free
   wire logic [7:0] nxt_doe = is_par ? {8{busy & ~rd_ff}} :
      is_spi ? 8'hFB : {5'h1F, 1'b0, i2_sda_lo, 1'b1};
   // data moves mid clock-low so the device never sees a false start
   wire logic sda_upd = ~is_i2c | ~busy | cnt_ff == mid;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LNK.cs_n <= 1'b1;
         LNK.data_cmd_sel <= 1'b0;
         LNK.rw_wr_n <= 1'b0;
         LNK.en_rd_n <= 1'b0;
         do_ff <= 8'h00;
         doe_ff <= 8'h00;
         strap_ff <= 3'h0;
      end else if (CE) begin
         LNK.cs_n <= ~busy;
         LNK.data_cmd_sel <= is_i2c ? sa0 : dc_ff;
         LNK.rw_wr_n <= is_pe ? rd_ff : is_prw & ~(strb & ~rd_ff);
         LNK.en_rd_n <= is_pe ? strb : is_prw & ~(strb & rd_ff);
         do_ff <= nxt_do;
         strap_ff <= ctrl_ff[2:0];
         doe_ff[7:2] <= nxt_doe[7:2];
         doe_ff[0] <= nxt_doe[0];
         if (sda_upd) doe_ff[1] <= nxt_doe[1];
      end
   end

   assign LNK.host_d_o = do_ff;
   assign LNK.host_d_oe = doe_ff;
   // straps flop with the enables so mode and drive switch together
   assign LNK.protocol_strap_0 = strap_ff[2];
   assign LNK.protocol_strap_1 = strap_ff[1];
   assign LNK.protocol_strap_2 = strap_ff[0];
   assign LNK.panel_reset_n = ~ctrl_ff[`DHI_CTRL_RESET_BIT];
endmodule
`default_nettype wire

// ===== tb/dhi_link_sva.sv
/*
 Checker for the pins between host and display device.
 Assumes host pins change on CLK; device enables are sampled on CLK too.
*/
`include "dhi_params.svh"
`timescale 1ns/100ps
`default_nettype none
module dhi_link_sva (
   // clock
   input wire logic CLK,
   input wire logic RST,
   // pins
   input wire logic protocol_strap_0,
   input wire logic protocol_strap_1,
   input wire logic protocol_strap_2,
   input wire logic cs_n,
   input wire logic rw_wr_n,
   input wire logic en_rd_n,
   input wire logic [7:0] host_d_oe,
   input wire logic [7:0] dev_d_oe,
   input wire logic [7:0] host_data_bus
);
   wire logic [2:0] st = {protocol_strap_0, protocol_strap_1,
      protocol_strap_2};
   wire logic par_e = st == `DHI_STRAP_PAR_E;
   wire logic par_rw = st == `DHI_STRAP_PAR_RW;
   wire logic spi = st == `DHI_STRAP_SPI4 || st == `DHI_STRAP_SPI3;
   wire logic ser = spi || st == `DHI_STRAP_I2C;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   chk_host_drive_sel: assert property (
      (par_e || par_rw) && host_d_oe != 8'h00 |-> !cs_n)
      else $error("host drives bus while deselected");
   chk_dev_drive_sel: assert property (
      dev_d_oe != 8'h00 |-> !cs_n) else $error("device drives unselected");
   chk_ser_strobes: assert property (
      ser [*3] |-> !rw_wr_n && !en_rd_n) else $error("strobes not low");
   chk_unused_low: assert property (
      ser [*3] |-> host_data_bus[7:3] == 5'h00)
      else $error("unused data lines not low");
   chk_spi_bit_hold: assert property (
      spi && !cs_n && host_data_bus[0] && $past(host_data_bus[0])
      |-> $stable(host_data_bus[1])) else $error("data moved, clock high");
   chk_dir_steady: assert property (
      par_e && !cs_n && en_rd_n |-> $stable(rw_wr_n))
      else $error("direction moved during enable");
   chk_split_wr_drive: assert property (
      par_rw && !cs_n && !rw_wr_n |-> host_d_oe == 8'hFF)
      else $error("write strobe without data");
   chk_e_read_turn: assert property (
      par_e && !cs_n && rw_wr_n && $rose(en_rd_n)
      |-> host_d_oe == 8'h00 ##[1:6] dev_d_oe == 8'hFF)
      else $error("device did not answer enable read");
   chk_split_rd_turn: assert property (
      par_rw && !cs_n && $fell(en_rd_n)
      |-> host_d_oe == 8'h00 ##[1:6] dev_d_oe == 8'hFF)
      else $error("device did not answer read strobe");
endmodule
`default_nettype wire

// ===== tb/display_host_interface_test.sv
/*
 Bench: APB host end facing the device end over the pin bundle.
 Assumes the default host timing parameters and free-running clocks.
*/
`include "dhi_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module display_host_interface_test;
   import dhi_pkg::*;
   typedef struct packed {
      logic [2:0] st;
      logic dc;
      logic [7:0] b;
      logic [7:0] con;
      logic on;
      dhi_mode_e m;
   } dhi_row_s;
   logic clk, link_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, rd_byte, rx_byte, cmd_byte, contrast, last_cmd;
   logic [31:0] pwdata, prdata, r;
   logic rx_valid, rx_is_data, display_on, in_reset;
   logic [8:0] got;
   dhi_mode_e mode;
   int errors, checked;
   logic [8:0] rx_q[$];
   dhi_row_s rows[11];
   dhi_if lnk();
   dhi_host i_dhi_host(.CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LNK(lnk));
   dhi_dev i_dhi_dev(.LINK_CLK(link_clk), .RST(rst), .CE(1'b1), .LNK(lnk),
      .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_IS_DATA(rx_is_data),
      .RD_BYTE(rd_byte), .MODE(mode), .CMD_BYTE(cmd_byte),
      .CONTRAST(contrast), .DISPLAY_ON(display_on), .IN_RESET(in_reset));
   dhi_link_sva i_dhi_link_sva(.CLK(clk), .RST(rst),
      .protocol_strap_0(lnk.protocol_strap_0),
      .protocol_strap_1(lnk.protocol_strap_1),
      .protocol_strap_2(lnk.protocol_strap_2), .cs_n(lnk.cs_n),
      .rw_wr_n(lnk.rw_wr_n), .en_rd_n(lnk.en_rd_n),
      .host_d_oe(lnk.host_d_oe), .dev_d_oe(lnk.dev_d_oe),
      .host_data_bus(lnk.host_data_bus));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // link clock offset so its edges never line up with the host clock
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   always @(posedge link_clk) begin
      if (rx_valid === 1'b1)
         rx_q.push_back({rx_is_data, rx_byte});
   end
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, `DHI_REG_STAT, 32'h0);
         n++;
      end while (r[0] !== 1'b0 && n < 4000);
      if (n >= 4000) begin
         errors++;
         print_verdict();
      end
      // device answers a few link edges after the last pin edge
      repeat (8) @(posedge link_clk);
      @(posedge clk);
   endtask
   task automatic send(input logic dc, input logic rd, input logic [7:0] b);
      apb(1'b1, `DHI_REG_TX, {22'h0, rd, dc, b});
      wait_idle();
   endtask
   task automatic strap(input logic [2:0] st, input logic sa, input logic rp);
      apb(1'b1, `DHI_REG_CTRL, {27'h0, sa, rp, st});
      repeat (6) @(posedge link_clk);
      @(posedge clk);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      print_verdict();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rd_byte = 8'h00;
      rows = '{'{`DHI_STRAP_SPI4, 1'b0, 8'hAF, 8'h7F, 1'b1, DHI_SPI4},
         '{`DHI_STRAP_SPI4, 1'b1, 8'h01, 8'h7F, 1'b1, DHI_SPI4},
         '{`DHI_STRAP_SPI3, 1'b1, 8'h5A, 8'h7F, 1'b1, DHI_SPI3},
         '{`DHI_STRAP_SPI3, 1'b0, 8'hAE, 8'h7F, 1'b0, DHI_SPI3},
         '{`DHI_STRAP_PAR_E, 1'b0, 8'h81, 8'h7F, 1'b0, DHI_PAR_E},
         '{`DHI_STRAP_PAR_E, 1'b0, 8'h3C, 8'h3C, 1'b0, DHI_PAR_E},
         '{`DHI_STRAP_PAR_RW, 1'b1, 8'hA5, 8'h3C, 1'b0, DHI_PAR_RW},
         '{`DHI_STRAP_PAR_RW, 1'b0, 8'hAF, 8'h3C, 1'b1, DHI_PAR_RW},
         '{`DHI_STRAP_I2C, 1'b0, 8'h81, 8'h3C, 1'b1, DHI_I2C},
         '{`DHI_STRAP_I2C, 1'b0, 8'hC3, 8'hC3, 1'b1, DHI_I2C},
         '{`DHI_STRAP_I2C, 1'b1, 8'h96, 8'hC3, 1'b1, DHI_I2C}};
      repeat (20) @(posedge clk);
      `CHK("contrast", 8'h7F, contrast)
      `CHK("display on", 1'b0, display_on)
      `CHK("in reset", 1'b1, in_reset)
      rst <= 1'b0;
      repeat (6) @(posedge link_clk);
      @(posedge clk);
      apb(1'b0, `DHI_REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h0, r)
      `CHK("ctrl err", 1'b0, err)
      `CHK("in reset", 1'b0, in_reset)
      $display("reset test done");
      foreach (rows[i]) begin
         // I2C rows also carry address bit one, on both ends
         strap(rows[i].st, rows[i].st == `DHI_STRAP_I2C, 1'b0);
         `CHK("mode", rows[i].m, mode)
         send(rows[i].dc, 1'b0, rows[i].b);
         `CHK("rx count", 1, rx_q.size())
         got = (rx_q.size() > 0) ? rx_q.pop_front() : 9'h0;
         `CHK("rx", {rows[i].dc, rows[i].b}, got)
         if (!rows[i].dc) last_cmd = rows[i].b;
         `CHK("cmd byte", last_cmd, cmd_byte)
         `CHK("contrast", rows[i].con, contrast)
         `CHK("display on", rows[i].on, display_on)
         $display("row %0d done", i);
      end
      for (int k = 0; k < 2; k++) begin
         strap(k ? `DHI_STRAP_PAR_RW : `DHI_STRAP_PAR_E, 1'b0, 1'b0);
         rd_byte <= 8'hC6 ^ 8'(k);
         send(1'b0, 1'b1, 8'h00);
         `CHK("read byte", 8'hC6 ^ 8'(k), r[15:8])
         `CHK("read rx", 0, rx_q.size())
         $display("read %0d done", k);
      end
      strap(`DHI_STRAP_SPI4, 1'b0, 1'b0);
      apb(1'b1, `DHI_REG_TX, {22'h0, 1'b0, 1'b1, 8'hA3});
      repeat (40) @(posedge clk);
      strap(`DHI_STRAP_SPI4, 1'b0, 1'b1);
      `CHK("in reset", 1'b1, in_reset)
      `CHK("contrast", 8'h7F, contrast)
      `CHK("display on", 1'b0, display_on)
      wait_idle();
      strap(`DHI_STRAP_SPI4, 1'b0, 1'b0);
      `CHK("partial", 0, rx_q.size())
      send(1'b1, 1'b0, 8'h5C);
      got = (rx_q.size() > 0) ? rx_q.pop_front() : 9'h0;
      `CHK("after reset", {1'b1, 8'h5C}, got)
      $display("panel reset done");
      strap(3'h7, 1'b0, 1'b0);
      `CHK("bad mode", DHI_BAD, mode)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, r)
      $display("odd cases done");
      print_verdict();
   end
endmodule
`default_nettype wire
